/* File: hw/pmc_consts.svh */
// constants for the power mode controller: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and design files
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PMC_OFF_ACT_TPL 8'h00
`define PMC_OFF_ALT_TPL 8'h04
`define PMC_OFF_MODE_REQ 8'h08
`define PMC_OFF_STATUS 8'h0c
`define PMC_OFF_WAKE_EN 8'h10
`define PMC_OFF_WAKE_FLAG 8'h14
`define PMC_OFF_PWC_CTRL 8'h18
`define PMC_OFF_PWC_CNT 8'h1c
`define PMC_OFF_REG_CTRL 8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define PMC_TPL_CPU_BIT 0
`define PMC_TPL_FLASH_BIT 1
`define PMC_REQ_ALT 2'h1
`define PMC_REQ_SLEEP 2'h2
`define PMC_REQ_HIB 2'h3
`define PMC_PWC_RESET_BIT 0
`define PMC_PWC_WAKE_BIT 1
`define PMC_REG_DIG_BIT 0
`define PMC_REG_ANA_BIT 1

// wake source bits
`define PMC_WK_CMP 0
`define PMC_WK_PIN 1
`define PMC_WK_I2C 2
`define PMC_WK_RTC 3
`define PMC_WK_PWC 4
`define PMC_WK_LVD 5

// ****************************************************************
// reset values
// ****************************************************************
`define PMC_RST_ACT_TPL 16'hffff
`define PMC_RST_ALT_TPL 16'hfffc
`define PMC_RST_WAKE_EN 6'h3f
`define PMC_RST_REG_CTRL 2'h3
`define PMC_RST_PWC_TERM 13'h1fff

// ****************************************************************
// timing
// ****************************************************************
`define PMC_CLK_HZ 50000000
`define PMC_PWC_HZ 1000
`define PMC_PWC_DIV (`PMC_CLK_HZ / `PMC_PWC_HZ)

`endif

/* File: hw/pmc_pkg.sv */
// types shared by the power mode controller
// assumes pmc_consts.svh is on the include path
`include "pmc_consts.svh"

package pmc_pkg;
	typedef enum logic [3:0] {
		PMC_ACTIVE = 4'h1,
		PMC_ALT = 4'h2,
		PMC_SLEEP = 4'h4,
		PMC_HIB = 4'h8
	} pmc_mode_e;
endpackage : pmc_pkg

/* File: hw/pmc_power_mode_controller.sv */
// global power mode controller with classic wishbone register slave
// assumes wake and reset event inputs come from outside and are synced here
//
// What this block does
// - exactly four modes: active, alternate active, sleep, hibernate, highest first
// - after boot the mode is active
// - each subsystem has its own bit in active and alternate templates
// - in active the active template gates subsystems, changes apply at once
// - disabled subsystem gets clock gated, bias removed, leakage reduced
// - cpu may disable itself and is re-enabled at next wakeup
// - any wakeup forces active mode and cpu enabled
// - alternate active uses its own template, cpu and flash may be off
// - sleep disables all subsystems regardless of templates
// - hibernate stops all clocks, keeps state, wakes only on pin interrupt
// - hibernate disables peripherals and regulators except hibernate regulator
// - core regulators on after power-up, firmware may disable them
// - external reset, watchdog and precision reset return to active
// - periodic counter 13 bits at 1 khz, runs except hibernate, resettable
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_power_mode_controller import pmc_pkg::*; #(
	parameter int NSUB = 16,
	parameter int PWC_DIV = `PMC_PWC_DIV
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// wake sources, asynchronous
	input wire logic comparator_wake,
	input wire logic pin_interrupt_unit,
	input wire logic i2c_addr_match,
	input wire logic rtc_wake,
	input wire logic low_voltage_detect,
	// reset events, asynchronous
	input wire logic external_reset_pin,
	input wire logic watchdog_reset_event,
	input wire logic precision_reset_event,
	// io supplies valid
	input wire logic io_supply_valid,
	// subsystem controls, one bit per subsystem
	output logic [NSUB-1:0] sub_clk_en,
	output logic [NSUB-1:0] sub_bias_off,
	output logic [NSUB-1:0] sub_leak_reduce,
	// clocks and regulators
	output logic low_speed_internal_osc_en,
	output logic watch_crystal_clock_en,
	output logic digital_core_supply_reg_en,
	output logic analog_core_supply_reg_en,
	output logic sleep_reg_en,
	output logic hib_reg_en,
	output logic [3:0] mode_o
);

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	localparam int NIN = 9;
	logic [NIN-1:0] sync1_reg, sync2_reg, in_raw;
	assign in_raw = {io_supply_valid, precision_reset_event,
		watchdog_reset_event, external_reset_pin, low_voltage_detect,
		rtc_wake, i2c_addr_match, pin_interrupt_unit, comparator_wake};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= in_raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic io_ok, rst_evt;
	assign io_ok = sync2_reg[8];
	assign rst_evt = |sync2_reg[7:5];

	// ****************************************************************
	// registers
	// ****************************************************************
	pmc_mode_e mode_reg;
	logic [NSUB-1:0] act_tpl_reg, alt_tpl_reg;
	logic [5:0] wake_en_reg, wake_flag_reg;
	logic [12:0] pwc_cnt_reg, pwc_term_reg;
	logic [1:0] reg_ctrl_reg;
	logic [31:0] div_cnt_reg;
	logic pwc_wake_en_reg, cpu_off_reg, tick, wake, pwc_reset_wr, pwc_hit;

	logic wb_req, wr;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr = wb_req && wb_we_i;

	function automatic logic hit(input logic [7:0] off);
		hit = (wb_adr_i == off);
	endfunction : hit

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `PMC_OFF_REG_CTRL);
	endfunction : mapped

	// ****************************************************************
	// periodic wake counter
	// ****************************************************************
	assign tick = (div_cnt_reg == 32'(PWC_DIV - 1));

	// divider and counter both stop in hibernate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt_reg <= '0;
		end else if (mode_reg == PMC_HIB || tick) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 32'h1;
		end
	end

	assign pwc_reset_wr = wr && hit(`PMC_OFF_PWC_CTRL) && wb_sel_i[0]
		&& wb_dat_i[`PMC_PWC_RESET_BIT];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pwc_cnt_reg <= '0;
		end else if (pwc_reset_wr) begin
			pwc_cnt_reg <= '0;
		end else if (tick && mode_reg != PMC_HIB) begin
			pwc_cnt_reg <= pwc_cnt_reg + 13'h1;
		end
	end

	assign pwc_hit = pwc_wake_en_reg && tick && mode_reg != PMC_HIB
		&& (pwc_cnt_reg == pwc_term_reg);

	// ****************************************************************
	// wake sources
	// ****************************************************************
	logic [5:0] wk_src, wk_allowed;
	assign wk_src = {sync2_reg[4], pwc_hit, sync2_reg[3], sync2_reg[2],
		sync2_reg[1], sync2_reg[0]};

	// sleep takes six sources, hibernate only the pin unit
	always_comb begin
		case (mode_reg)
			PMC_SLEEP: wk_allowed = wk_src & wake_en_reg;
			PMC_HIB: wk_allowed = wk_src & 6'h02;
			default: wk_allowed = wk_src & wake_en_reg;
		endcase
	end
	assign wake = |wk_allowed;

	// flags: set wins over write-one clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wake_flag_reg <= '0;
		end else begin
			wake_flag_reg <= (wake_flag_reg & ~((wr && hit(`PMC_OFF_WAKE_FLAG)
				&& wb_sel_i[0]) ? wb_dat_i[5:0] : 6'h0)) | wk_allowed;
		end
	end

	// ****************************************************************
	// mode machine
	// ****************************************************************
	logic [1:0] req;
	logic req_wr;
	assign req = wb_dat_i[1:0];
	assign req_wr = wr && hit(`PMC_OFF_MODE_REQ) && wb_sel_i[0];

	// boot lands in active; resets and wakes also return there
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= PMC_ACTIVE;
		end else if (rst_evt || wake) begin
			mode_reg <= PMC_ACTIVE;
		end else if (req_wr) begin
			case (req)
				`PMC_REQ_ALT: mode_reg <= PMC_ALT;
				// low-power entry refused until io supplies are valid
				`PMC_REQ_SLEEP: mode_reg <= io_ok ? PMC_SLEEP : mode_reg;
				`PMC_REQ_HIB: mode_reg <= io_ok ? PMC_HIB : mode_reg;
				default: mode_reg <= PMC_ACTIVE;
			endcase
		end
	end

	// cpu self-disable, cleared by any wakeup
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cpu_off_reg <= 1'b0;
		end else if (rst_evt || wake) begin
			cpu_off_reg <= 1'b0;
		end else if (wr && hit(`PMC_OFF_STATUS) && wb_sel_i[0]) begin
			cpu_off_reg <= wb_dat_i[0];
		end
	end

	// ****************************************************************
	// config registers
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			act_tpl_reg <= NSUB'(`PMC_RST_ACT_TPL);
			alt_tpl_reg <= NSUB'(`PMC_RST_ALT_TPL);
			wake_en_reg <= `PMC_RST_WAKE_EN;
			pwc_term_reg <= `PMC_RST_PWC_TERM;
			pwc_wake_en_reg <= 1'b0;
			reg_ctrl_reg <= `PMC_RST_REG_CTRL;
		end else begin
			if (wr && hit(`PMC_OFF_ACT_TPL)) begin
				act_tpl_reg <= wb_dat_i[NSUB-1:0];
			end
			if (wr && hit(`PMC_OFF_ALT_TPL)) begin
				alt_tpl_reg <= wb_dat_i[NSUB-1:0];
			end
			if (wr && hit(`PMC_OFF_WAKE_EN) && wb_sel_i[0]) begin
				wake_en_reg <= wb_dat_i[5:0];
			end
			if (wr && hit(`PMC_OFF_PWC_CTRL)) begin
				pwc_wake_en_reg <= wb_dat_i[`PMC_PWC_WAKE_BIT];
				pwc_term_reg <= wb_dat_i[28:16];
			end
			if (wr && hit(`PMC_OFF_REG_CTRL) && wb_sel_i[0]) begin
				reg_ctrl_reg <= wb_dat_i[1:0];
			end
			// wake overrides a cleared cpu template bit, even one just written
			if (rst_evt || wake) begin
				act_tpl_reg[`PMC_TPL_CPU_BIT] <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// subsystem gating
	// ****************************************************************
	logic [NSUB-1:0] en_next;
	always_comb begin
		case (mode_reg)
			PMC_ACTIVE: en_next = act_tpl_reg;
			PMC_ALT: en_next = alt_tpl_reg;
			PMC_SLEEP: en_next = '0;
			PMC_HIB: en_next = '0;
			default: en_next = act_tpl_reg;
		endcase
		// cpu bit follows template in active modes, unless self-disabled
		if (cpu_off_reg) begin
			en_next[`PMC_TPL_CPU_BIT] = 1'b0;
		end
	end

	// registered so gating changes land on a clean cycle boundary
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sub_clk_en <= NSUB'(`PMC_RST_ACT_TPL);
			sub_bias_off <= ~NSUB'(`PMC_RST_ACT_TPL);
			sub_leak_reduce <= ~NSUB'(`PMC_RST_ACT_TPL);
		end else begin
			sub_clk_en <= en_next;
			sub_bias_off <= ~en_next;
			sub_leak_reduce <= ~en_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_speed_internal_osc_en <= 1'b1;
			watch_crystal_clock_en <= 1'b1;
			digital_core_supply_reg_en <= 1'b1;
			analog_core_supply_reg_en <= 1'b1;
			sleep_reg_en <= 1'b1;
			hib_reg_en <= 1'b1;
		end else begin
			low_speed_internal_osc_en <= (mode_reg != PMC_HIB);
			watch_crystal_clock_en <= (mode_reg != PMC_HIB);
			digital_core_supply_reg_en <= (mode_reg != PMC_HIB)
				&& reg_ctrl_reg[`PMC_REG_DIG_BIT];
			analog_core_supply_reg_en <= (mode_reg != PMC_HIB)
				&& reg_ctrl_reg[`PMC_REG_ANA_BIT];
			sleep_reg_en <= (mode_reg != PMC_HIB);
			hib_reg_en <= 1'b1;
		end
	end

	assign mode_o = mode_reg;

	// ****************************************************************
	// wishbone answer, one cycle after request
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req && mapped(wb_adr_i);
			wb_err_o <= wb_req && !mapped(wb_adr_i);
			wb_dat_o <= '0;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`PMC_OFF_ACT_TPL: wb_dat_o <= 32'(act_tpl_reg);
					`PMC_OFF_ALT_TPL: wb_dat_o <= 32'(alt_tpl_reg);
					`PMC_OFF_STATUS: wb_dat_o <= {23'h0, io_ok, mode_reg,
						3'h0, cpu_off_reg};
					`PMC_OFF_WAKE_EN: wb_dat_o <= {26'h0, wake_en_reg};
					`PMC_OFF_WAKE_FLAG: wb_dat_o <= {26'h0, wake_flag_reg};
					`PMC_OFF_PWC_CTRL: wb_dat_o <= {3'h0, pwc_term_reg,
						14'h0, pwc_wake_en_reg, 1'b0};
					`PMC_OFF_PWC_CNT: wb_dat_o <= {19'h0, pwc_cnt_reg};
					`PMC_OFF_REG_CTRL: wb_dat_o <= {30'h0, reg_ctrl_reg};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_mode_onehot: assert property (@(posedge ref_clk) disable iff (rst)
		$onehot(mode_reg)) else $error("mode not one of four");
	sequence s_wake;
		wake && !rst_evt;
	endsequence
	a_wake_active: assert property (@(posedge ref_clk) disable iff (rst)
		s_wake |=> mode_reg == PMC_ACTIVE && !cpu_off_reg)
		else $error("wake did not return to active");
	a_cpu_back: assert property (@(posedge ref_clk) disable iff (rst)
		s_wake |=> ##1 sub_clk_en[`PMC_TPL_CPU_BIT])
		else $error("cpu not re-enabled");
	a_sleep_gated: assert property (@(posedge ref_clk) disable iff (rst)
		mode_reg == PMC_SLEEP |=> sub_clk_en == '0)
		else $error("sleep left subsystems on");
	a_gate_pairs: assert property (@(posedge ref_clk) disable iff (rst)
		sub_bias_off == ~sub_clk_en && sub_leak_reduce == ~sub_clk_en)
		else $error("bias or leak mismatch");
	a_active_tpl: assert property (@(posedge ref_clk) disable iff (rst)
		mode_reg == PMC_ACTIVE && !cpu_off_reg && $stable(mode_reg)
		|=> sub_clk_en == $past(act_tpl_reg))
		else $error("active template not applied");
	a_hib_pin_only: assert property (@(posedge ref_clk) disable iff (rst)
		mode_reg == PMC_HIB && !wk_src[`PMC_WK_PIN] && !rst_evt
		|=> mode_reg == PMC_HIB || $past(req_wr))
		else $error("hibernate woke without pin");
	a_hib_regs: assert property (@(posedge ref_clk) disable iff (rst)
		mode_reg == PMC_HIB ##1 mode_reg == PMC_HIB
		|-> !digital_core_supply_reg_en && !sleep_reg_en && hib_reg_en)
		else $error("hibernate regulators wrong");
	a_pwc_frozen: assert property (@(posedge ref_clk) disable iff (rst)
		mode_reg == PMC_HIB && !pwc_reset_wr |=> $stable(pwc_cnt_reg))
		else $error("counter ran in hibernate");
	a_io_guard: assert property (@(posedge ref_clk) disable iff (rst)
		req_wr && !io_ok && !wake && !rst_evt && req != `PMC_REQ_ALT
		|=> mode_reg != PMC_SLEEP && mode_reg != PMC_HIB)
		else $error("low power entered without valid io");

endmodule : pmc_power_mode_controller

/* File: dv/pmc_power_mode_controller_bench.sv */
// self-checking bench for the power mode controller
// assumes hw/pmc_consts.svh and hw/pmc_pkg.sv are compiled first
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_power_mode_controller_bench import pmc_pkg::*;;
	// ****************************************************************
	// signals and design
	// ****************************************************************
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, wb_err_o;
	logic [4:0] wk = 5'h00;
	logic [2:0] rv = 3'h0;
	logic io_supply_valid = 1'b0;
	logic [15:0] sub_clk_en, sub_bias_off, sub_leak_reduce;
	logic osc_en, xtal_en, dig_en, ana_en, slp_en, hib_en;
	logic [3:0] mode_o;
	logic [64:0] exp_q[$];
	logic [64:0] e;
	logic [31:0] lf = 32'h9a13;
	logic [15:0] at, al;
	int err_count = 0, check_count = 0, cyc_n = 0, n;

	pmc_power_mode_controller #(.NSUB(16), .PWC_DIV(4)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.comparator_wake(wk[0]), .pin_interrupt_unit(wk[1]),
		.i2c_addr_match(wk[2]), .rtc_wake(wk[3]),
		.low_voltage_detect(wk[4]), .external_reset_pin(rv[0]),
		.watchdog_reset_event(rv[1]), .precision_reset_event(rv[2]),
		.io_supply_valid(io_supply_valid), .sub_clk_en(sub_clk_en),
		.sub_bias_off(sub_bias_off), .sub_leak_reduce(sub_leak_reduce),
		.low_speed_internal_osc_en(osc_en), .watch_crystal_clock_en(xtal_en),
		.digital_core_supply_reg_en(dig_en),
		.analog_core_supply_reg_en(ana_en),
		.sleep_reg_en(slp_en), .hib_reg_en(hib_en), .mode_o(mode_o)
	);

	always #10 ref_clk = ~ref_clk;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [15:0] got, input logic [15:0] exp, input string w);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk

	// masked compare of one bus answer against its note
	task chk_bus(input logic [64:0] x, input logic er, input logic [31:0] d);
		check_count++;
		if (er !== x[64] || ((d ^ x[31:0]) & x[63:32]) !== 32'h0) begin
			err_count++;
			$display("ERROR %0t bus answer err %b dat %h", $time, er, d);
		end
	endtask : chk_bus

	// one classic cycle; the note goes in before the request
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic er, input logic [31:0] m);
		exp_q.push_back({er, m, d});
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= we ? d : 32'h0;
		// no answer latency assumed; the run ceiling ends a hang
		do begin
			@(posedge ref_clk);
		end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 1'b0, 32'h0);
	endtask : wr

	task cw(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cw

	task done(input string s);
		$display("test %s done", s);
	endtask : done

	// ****************************************************************
	// answer watcher and hang guard
	// ****************************************************************
	always @(posedge ref_clk) begin
		if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("ERROR %0t answer without request", $time);
			end else begin
				e = exp_q.pop_front();
				chk_bus(e, wb_err_o, wb_dat_o);
			end
		end
	end

	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			$display("ERROR %0t run too long", $time);
			tally_and_finish;
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		cw(12);
		rst <= 1'b0;
		cw(2);
		chk({12'h0, mode_o}, {12'h0, PMC_ACTIVE}, "boot mode");
		chk(sub_clk_en, 16'hffff, "boot enables");
		chk({14'h0, dig_en, ana_en}, 16'h3, "boot regs");
		wb(0, `PMC_OFF_ACT_TPL, 32'hffff, 0, 32'hffff);
		wb(0, `PMC_OFF_ALT_TPL, 32'hfffc, 0, 32'hffff);
		wb(0, `PMC_OFF_REG_CTRL, 32'h3, 0, 32'h3);
		wb(0, 8'h24, 32'h0, 1, 32'h0);
		wb(0, 8'h05, 32'h0, 1, 32'h0);
		done("reset");
		// io supplies not yet valid: sleep must be ignored
		wr(`PMC_OFF_MODE_REQ, {30'h0, `PMC_REQ_SLEEP});
		cw(3);
		chk({12'h0, mode_o}, {12'h0, PMC_ACTIVE}, "early sleep");
		io_supply_valid <= 1'b1;
		cw(3);
		lf = lfsr_next(lf);
		at = lf[15:0] | 16'h0001;
		wr(`PMC_OFF_ACT_TPL, {16'h0, at});
		cw(3);
		chk(sub_clk_en, at, "active tpl");
		chk(sub_bias_off, ~at, "bias");
		chk(sub_leak_reduce, ~at, "leak");
		wr(`PMC_OFF_STATUS, 32'h1);
		cw(3);
		chk({15'h0, sub_clk_en[0]}, 16'h0, "cpu off");
		wk <= 5'h08;
		cw(6);
		chk({15'h0, sub_clk_en[0]}, 16'h1, "cpu back");
		wk <= 5'h00;
		done("active");
		lf = lfsr_next(lf);
		al = lf[15:0] & 16'hfffc;
		wr(`PMC_OFF_ALT_TPL, {16'h0, al});
		wr(`PMC_OFF_MODE_REQ, {30'h0, `PMC_REQ_ALT});
		cw(3);
		chk({12'h0, mode_o}, {12'h0, PMC_ALT}, "alt mode");
		chk(sub_clk_en, al, "alt tpl");
		wb(0, `PMC_OFF_STATUS, {24'h0, PMC_ALT, 4'h0}, 0, 32'hf0);
		// cpu bit cleared in the template: the wake must still bring it back
		wr(`PMC_OFF_ACT_TPL, {16'h0, at & 16'hfffe});
		wk <= 5'h10;
		cw(6);
		chk({12'h0, mode_o}, {12'h0, PMC_ACTIVE}, "alt wake");
		chk({15'h0, sub_clk_en[0]}, 16'h1, "cpu forced");
		wk <= 5'h00;
		// let the dropped wake drain through the synchroniser first
		cw(3);
		for (int i = 0; i < 3; i++) begin
			wr(`PMC_OFF_MODE_REQ, {30'h0, `PMC_REQ_ALT});
			cw(3);
			chk({12'h0, mode_o}, {12'h0, PMC_ALT}, "alt again");
			rv <= 3'h1 << i;
			cw(6);
			chk({12'h0, mode_o}, {12'h0, PMC_ACTIVE}, "reset event");
			rv <= 3'h0;
			cw(3);
		end
		done("alternate");
		// each of the five external sleep wake sources in turn
		for (int i = 0; i < 5; i++) begin
			wr(`PMC_OFF_MODE_REQ, {30'h0, `PMC_REQ_SLEEP});
			cw(3);
			chk({12'h0, mode_o}, {12'h0, PMC_SLEEP}, "sleep");
			chk({15'h0, sub_clk_en[0]}, 16'h0, "sleep cpu");
			chk({14'h0, osc_en, xtal_en}, 16'h3, "slow clocks");
			wk <= 5'h01 << i;
			cw(6);
			chk({12'h0, mode_o}, {12'h0, PMC_ACTIVE}, "sleep wake");
			wk <= 5'h00;
			cw(3);
		end
		// cmp, pin, i2c, rtc and lvd have all fired by now
		wb(0, `PMC_OFF_WAKE_FLAG, 32'h2f, 0, 32'h3f);
		wr(`PMC_OFF_WAKE_FLAG, 32'h3f);
		wb(0, `PMC_OFF_WAKE_FLAG, 32'h0, 0, 32'h3f);
		done("sleep");
		wr(`PMC_OFF_MODE_REQ, {30'h0, `PMC_REQ_HIB});
		cw(3);
		chk({12'h0, mode_o}, {12'h0, PMC_HIB}, "hibernate");
		chk(sub_clk_en, 16'h0, "hib clocks");
		chk({10'h0, osc_en, xtal_en, dig_en, ana_en, slp_en, hib_en},
			16'h1, "hib regs");
		wk <= 5'h08;
		cw(8);
		chk({12'h0, mode_o}, {12'h0, PMC_HIB}, "rtc ignored");
		wk <= 5'h0a;
		cw(6);
		chk({12'h0, mode_o}, {12'h0, PMC_ACTIVE}, "pin wake");
		wk <= 5'h00;
		wb(0, `PMC_OFF_ACT_TPL, {16'h0, at}, 0, 32'hffff);
		done("hibernate");
		wr(`PMC_OFF_REG_CTRL, 32'h0);
		cw(3);
		chk({14'h0, dig_en, ana_en}, 16'h0, "regs off");
		wr(`PMC_OFF_REG_CTRL, 32'h3);
		done("regulators");
		// terminal 40 ticks of 4 clocks, counter cleared, wake enabled
		wr(`PMC_OFF_PWC_CTRL, 32'h0028_0003);
		wr(`PMC_OFF_MODE_REQ, {30'h0, `PMC_REQ_SLEEP});
		cw(3);
		chk({12'h0, mode_o}, {12'h0, PMC_SLEEP}, "timed sleep");
		n = 0;
		while (mode_o !== PMC_ACTIVE && n < 400) begin
			n++;
			@(posedge ref_clk);
		end
		chk({15'h0, (n >= 130 && n <= 180)}, 16'h1, "wake time");
		wr(`PMC_OFF_PWC_CTRL, 32'h0);
		done("periodic");
		cw(4);
		tally_and_finish;
	end
endmodule : pmc_power_mode_controller_bench
